// file: hdl/rpt_top.v
// Protocol timer and carrier-sense configuration bank with serial
// register port, wake-up timing, back-off generator, switch tick.
// Assumes a mode 0 serial master, MSB first, and same-clock inputs
// for sync detection, sleep entry and protocol control bits.
`timescale 1ns/1ns
`include "rpt_map.vh"
module rpt_top (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire spi_sclk_i,
  input wire spi_mosi_i,
  input wire spi_csn_i,
  output reg spi_miso_o,
  output reg spi_miso_oe_o,
  input wire rco_tick_i,
  input wire gpio_slow_clk_i,
  input wire sleep_enter_i,
  input wire low_duty_cycle_mode_i,
  input wire sync_detect_i,
  input wire reload_on_sync_enable_i,
  input wire seed_reload_i,
  input wire carrier_sense_access_enable_i,
  input wire backoff_step_i,
  output reg wake_o,
  output reg [15:0] backoff_rand_o,
  output reg [5:0] backoff_unit_prescale_o,
  output reg [9:0] cca_bit_periods_o,
  output reg [3:0] listen_length_o,
  output reg [2:0] backoff_cycle_limit_o,
  output reg [31:0] tx_control_field_o,
  output reg regulator_on_o,
  output reg smps_switch_o,
  output reg temp_sensor_buffer_enable_o,
  output reg external_slow_clock_select_o
);
  reg [7:0] wk_pre_q;
  reg [7:0] wk_cnt_q;
  reg [7:0] rl_pre_q;
  reg [7:0] rl_cnt_q;
  reg [7:0] seed_h_q;
  reg [7:0] seed_l_q;
  reg [7:0] unit_cca_q;
  reg [7:0] len_lim_q;
  reg [7:0] txc_q [0:3];
  reg [7:0] pm2_q;
  reg [7:0] pm1_q;
  reg [7:0] pm0_q;
  reg [7:0] xo_q;
  reg [2:0] sclk_s_q;
  reg [1:0] mosi_s_q;
  reg [1:0] csn_s_q;
  reg [2:0] gclk_s_q;
  reg [2:0] bit_q;
  reg [1:0] phase_q;
  reg [7:0] rx_q;
  reg [7:0] tx_q;
  reg [7:0] hdr_q;
  reg [7:0] addr_q;
  reg reload_cmd_q;
  reg use_reload_q;
  reg [14:0] acc_q;
  reg [1:0] div_q;
  reg slow_tick_d;
  reg [7:0] rx_d;
  wire sclk_rise;
  wire sclk_fall;
  wire byte_done;
  wire rel_evt;
  wire tmr_start;
  wire tmr_expire;
  wire tmr_run;
  wire [15:0] rng_val;
  wire [15:0] acc_sum;
  integer i;
  localparam PH_HDR = 2'b01;
  localparam PH_ADR = 2'b10;
  localparam PH_DAT = 2'b00;
  ////////////////////////////////////////////////////////////////////
  // Read mux, unmapped offsets read zero
  function [7:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `RPT_OFS_WK_PRE: rd_mux = wk_pre_q;
        `RPT_OFS_WK_CNT: rd_mux = wk_cnt_q;
        `RPT_OFS_RL_PRE: rd_mux = rl_pre_q;
        `RPT_OFS_RL_CNT: rd_mux = rl_cnt_q;
        `RPT_OFS_SEED_H: rd_mux = seed_h_q;
        `RPT_OFS_SEED_L: rd_mux = seed_l_q;
        `RPT_OFS_UNIT_CCA: rd_mux = unit_cca_q;
        `RPT_OFS_LEN_LIM: rd_mux = len_lim_q;
        `RPT_OFS_TXC3: rd_mux = txc_q[3];
        `RPT_OFS_TXC2: rd_mux = txc_q[2];
        `RPT_OFS_TXC1: rd_mux = txc_q[1];
        `RPT_OFS_TXC0: rd_mux = txc_q[0];
        `RPT_OFS_PM2: rd_mux = pm2_q;
        `RPT_OFS_PM1: rd_mux = pm1_q;
        `RPT_OFS_PM0: rd_mux = pm0_q;
        `RPT_OFS_XO: rd_mux = xo_q;
        `RPT_OFS_TSEL: rd_mux = `RPT_RST_TSEL; // [RQ19]
        `RPT_OFS_PTST: rd_mux = `RPT_RST_PTST; // [RQ19]
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction
  // Keeps reserved bits at their reset value
  function [7:0] merge;
    input [7:0] wdata;
    input [7:0] rstv;
    input [7:0] mask;
    begin
      merge = (wdata & mask) | (rstv & ~mask); // [RQ19]
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only stage two and beyond are read
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sclk_s_q <= 3'b000;
      mosi_s_q <= 2'b00;
      csn_s_q <= 2'b11;
      gclk_s_q <= 3'b000;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[1:0], spi_sclk_i};
      mosi_s_q <= {mosi_s_q[0], spi_mosi_i};
      csn_s_q <= {csn_s_q[0], spi_csn_i};
      gclk_s_q <= {gclk_s_q[1:0], gpio_slow_clk_i};
    end
  end
  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2] & ~csn_s_q[1];
  assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2] & ~csn_s_q[1];
  assign byte_done = sclk_rise && (bit_q == 3'd7);
  always @*
  begin
    rx_d = {rx_q[6:0], mosi_s_q[1]};
  end

  ////////////////////////////////////////////////////////////////////
  // Serial frame: header, address, then data with auto-increment
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bit_q <= 3'd0;
      phase_q <= PH_HDR;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      hdr_q <= 8'h00;
      addr_q <= 8'h00;
      reload_cmd_q <= 1'b0;
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end
    else
    begin
      reload_cmd_q <= 1'b0;
      spi_miso_oe_o <= ~csn_s_q[1];
      if (csn_s_q[1])
      begin
        bit_q <= 3'd0;
        phase_q <= PH_HDR;
        spi_miso_o <= 1'b0;
      end
      else
      begin
        if (sclk_rise)
        begin
          rx_q <= rx_d;
          bit_q <= bit_q + 3'd1;
        end
        if (sclk_fall)
        begin
          spi_miso_o <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
        if (byte_done)
        begin
          case (phase_q)
            PH_HDR:
            begin
              hdr_q <= rx_d;
              phase_q <= PH_ADR;
            end
            PH_ADR:
            begin
              addr_q <= rx_d;
              phase_q <= PH_DAT;
              tx_q <= rd_mux(rx_d);
              if (hdr_q == `RPT_HDR_CMD &&
                  rx_d == `RPT_CMD_TMR_RELOAD)
                reload_cmd_q <= 1'b1; // [RQ3]
            end
            PH_DAT:
            begin
              addr_q <= addr_q + 8'd1;
              tx_q <= rd_mux(addr_q + 8'd1);
            end
            default: phase_q <= PH_HDR;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register bank writes
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wk_pre_q <= `RPT_RST_WK_PRE; // [RQ19]
      wk_cnt_q <= `RPT_RST_CNT;
      rl_pre_q <= `RPT_RST_WK_PRE;
      rl_cnt_q <= `RPT_RST_CNT;
      seed_h_q <= `RPT_RST_SEED_H; // [RQ4]
      seed_l_q <= `RPT_RST_SEED_L; // [RQ4]
      unit_cca_q <= `RPT_RST_UNIT_CCA; // [RQ5]
      len_lim_q <= `RPT_RST_LEN_LIM; // [RQ7] [RQ8]
      for (i = 0; i < 4; i = i + 1)
        txc_q[i] <= 8'h00;
      pm2_q <= `RPT_RST_PM2;
      pm1_q <= `RPT_RST_PM1;
      pm0_q <= `RPT_RST_PM0;
      xo_q <= `RPT_RST_XO;
    end
    else if (byte_done && phase_q == PH_DAT &&
             hdr_q == `RPT_HDR_WRITE)
    begin
      case (addr_q)
        `RPT_OFS_WK_PRE: wk_pre_q <= rx_d;
        `RPT_OFS_WK_CNT: wk_cnt_q <= rx_d;
        `RPT_OFS_RL_PRE: rl_pre_q <= rx_d;
        `RPT_OFS_RL_CNT: rl_cnt_q <= rx_d;
        `RPT_OFS_SEED_H: seed_h_q <= rx_d;
        `RPT_OFS_SEED_L: seed_l_q <= rx_d;
        `RPT_OFS_UNIT_CCA: unit_cca_q <= rx_d;
        `RPT_OFS_LEN_LIM:
          len_lim_q <= merge(rx_d, `RPT_RST_LEN_LIM, `RPT_WM_LEN_LIM);
        `RPT_OFS_TXC3: txc_q[3] <= rx_d; // [RQ9]
        `RPT_OFS_TXC2: txc_q[2] <= rx_d;
        `RPT_OFS_TXC1: txc_q[1] <= rx_d;
        `RPT_OFS_TXC0: txc_q[0] <= rx_d;
        `RPT_OFS_PM2: pm2_q <= merge(rx_d, `RPT_RST_PM2, `RPT_WM_PM2);
        `RPT_OFS_PM1: pm1_q <= rx_d;
        `RPT_OFS_PM0: pm0_q <= rx_d;
        `RPT_OFS_XO: xo_q <= merge(rx_d, `RPT_RST_XO, `RPT_WM_XO);
        default: pm0_q <= pm0_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Slow clock source: internal tick or synchronised pin edge
  always @*
  begin
    if (xo_q[`RPT_BIT_EXT_SLOW])
      slow_tick_d = gclk_s_q[1] & ~gclk_s_q[2]; // [RQ12]
    else
      slow_tick_d = rco_tick_i;
  end

  ////////////////////////////////////////////////////////////////////
  // Wake-up timing; a reload while running restarts with the reload pair
  assign rel_evt = reload_cmd_q |
    (sync_detect_i & reload_on_sync_enable_i); // [RQ3] [RQ16]
  assign tmr_start = (sleep_enter_i & low_duty_cycle_mode_i) |
    (rel_evt & tmr_run);
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      use_reload_q <= 1'b0;
    else if (rel_evt)
      use_reload_q <= 1'b1;
    else if (tmr_expire)
      use_reload_q <= 1'b0;
  end

  rpt_wake_timer #(
    .W(8)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .start_i(tmr_start),
    .stop_i(~low_duty_cycle_mode_i),
    .slow_tick_i(slow_tick_d),
    .prescale_i((use_reload_q | rel_evt) ? rl_pre_q : wk_pre_q), // [RQ2]
    .count_i((use_reload_q | rel_evt) ? rl_cnt_q : wk_cnt_q), // [RQ1]
    .expire_o(tmr_expire),
    .running_o(tmr_run)
  );

  ////////////////////////////////////////////////////////////////////
  // Back-off generator steps only with carrier-sense access on
  rpt_backoff_rng u_rng (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .load_i(seed_reload_i), // [RQ15]
    .step_i(backoff_step_i & carrier_sense_access_enable_i), // [RQ17]
    .seed_i({seed_h_q, seed_l_q}), // [RQ4]
    .value_o(rng_val)
  );

  ////////////////////////////////////////////////////////////////////
  // Switch tick: carry of a 15-bit phase accumulator or divide by 4
  assign acc_sum = {1'b0, acc_q} + {1'b0, pm1_q[6:0], pm0_q}; // [RQ11]
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      acc_q <= 15'h0000;
      div_q <= 2'b00;
      smps_switch_o <= 1'b0;
    end
    else if (!pm2_q[`RPT_BIT_REG_DIS])
    begin
      if (pm1_q[`RPT_BIT_RM_SEL])
      begin
        acc_q <= acc_sum[14:0];
        smps_switch_o <= acc_sum[15]; // [RQ10]
      end
      else
      begin
        div_q <= div_q + 2'd1;
        smps_switch_o <= (div_q == 2'd3); // [RQ10]
      end
    end
    else
      smps_switch_o <= 1'b0; // [RQ13]
  end

  ////////////////////////////////////////////////////////////////////
  // Registered configuration outputs
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wake_o <= 1'b0;
      backoff_rand_o <= 16'h0000;
      backoff_unit_prescale_o <= 6'h01;
      cca_bit_periods_o <= `RPT_CCA_BASE;
      listen_length_o <= 4'h0;
      backoff_cycle_limit_o <= 3'h0;
      tx_control_field_o <= 32'h0000_0000;
      regulator_on_o <= 1'b0;
      temp_sensor_buffer_enable_o <= 1'b0;
      external_slow_clock_select_o <= 1'b0;
    end
    else
    begin
      wake_o <= tmr_expire; // [RQ1] [RQ2]
      backoff_rand_o <= carrier_sense_access_enable_i ?
        rng_val : 16'h0000; // [RQ17]
      backoff_unit_prescale_o <= unit_cca_q[7:2]; // [RQ5]
      cca_bit_periods_o <= `RPT_CCA_BASE << unit_cca_q[1:0]; // [RQ6]
      listen_length_o <= len_lim_q[7:4]; // [RQ7]
      backoff_cycle_limit_o <= len_lim_q[2:0]; // [RQ8]
      tx_control_field_o <= {txc_q[3], txc_q[2], txc_q[1], txc_q[0]};
      regulator_on_o <= ~pm2_q[`RPT_BIT_REG_DIS]; // [RQ13]
      temp_sensor_buffer_enable_o <= pm2_q[`RPT_BIT_TS_BUF]; // [RQ14]
      external_slow_clock_select_o <= xo_q[`RPT_BIT_EXT_SLOW]; // [RQ12]
    end
  end
endmodule

// file: hdl/rpt_map.vh
// Register map, field positions, reset values and command codes
// of the radio protocol timer and carrier-sense configuration bank.
// Assumes inclusion by bare name from the design files of this block.
//
// Contract
// (RQ1) Wake-up timer sleep period from 8-bit prescale and count; expiry ends sleep.
// (RQ2) Separate reload prescale and count; their expiry also ends sleep.
// (RQ3) Reload values used after sync word detection or timer reload command.
// (RQ4) 16-bit back-off seed; high byte resets to ones, low to zero.
// (RQ5) 6-bit back-off unit prescale in bits 7:2, reset value one.
// (RQ6) Assessment period code 0..3 selects 64, 128, 256, 512 bit periods.
// (RQ7) Listen length in upper nibble, reset zero.
// (RQ8) Back-off cycle limit in bits 2:0, reset zero.
// (RQ9) Four control-field bytes, byte three down to zero, go into packets.
// (RQ10) Regulator switches at osc/4, or osc times multiplier over 2^15.
// (RQ11) 15-bit multiplier: seven high bits then eight low bits.
// (RQ12) External slow clock select takes the slow clock from a pin.
// (RQ13) Regulator runs while disable bit 5 is zero, off when one.
// (RQ14) Temperature sensor output buffered while bit 6 set; resets zero.
// (RQ15) Seed reload control loads the programmed seed into the generator.
// (RQ16) Reload-on-sync enable reloads the wake-up timer from reload values.
// (RQ17) Back-off procedure used only while carrier-sense access enabled.
// (RQ18) Each interval is prescale times count slow-clock periods.
// (RQ19) Reset values after reset; reserved bits keep them on writes.
////////////////////////////////////////////////////////////////////////
`ifndef RPT_MAP_VH
`define RPT_MAP_VH

`define RPT_OFS_WK_PRE 8'h55
`define RPT_OFS_WK_CNT 8'h56
`define RPT_OFS_RL_PRE 8'h57
`define RPT_OFS_RL_CNT 8'h58
`define RPT_OFS_SEED_H 8'h64
`define RPT_OFS_SEED_L 8'h65
`define RPT_OFS_UNIT_CCA 8'h66
`define RPT_OFS_LEN_LIM 8'h67
`define RPT_OFS_TXC3 8'h68
`define RPT_OFS_TXC2 8'h69
`define RPT_OFS_TXC1 8'h6a
`define RPT_OFS_TXC0 8'h6b
`define RPT_OFS_PM2 8'ha4
`define RPT_OFS_PM1 8'ha5
`define RPT_OFS_PM0 8'ha6
`define RPT_OFS_XO 8'ha7
`define RPT_OFS_TSEL 8'ha8
`define RPT_OFS_PTST 8'hb2

`define RPT_RST_WK_PRE 8'h01
`define RPT_RST_CNT 8'h00
`define RPT_RST_SEED_H 8'hff
`define RPT_RST_SEED_L 8'h00
`define RPT_RST_UNIT_CCA 8'h04
`define RPT_RST_LEN_LIM 8'h00
`define RPT_RST_PM2 8'h0c
`define RPT_RST_PM1 8'h20
`define RPT_RST_PM0 8'h00
`define RPT_RST_XO 8'he1
`define RPT_RST_TSEL 8'h00
`define RPT_RST_PTST 8'h42

// Writable bit masks; other bits hold their reset value
`define RPT_WM_LEN_LIM 8'hf7
`define RPT_WM_PM2 8'h6c
`define RPT_WM_XO 8'h08

`define RPT_BIT_TS_BUF 6
`define RPT_BIT_REG_DIS 5
`define RPT_BIT_RM_SEL 7
`define RPT_BIT_EXT_SLOW 3

// Serial header bytes and command codes
`define RPT_HDR_WRITE 8'h00
`define RPT_HDR_READ 8'h01
`define RPT_HDR_CMD 8'h80
`define RPT_CMD_TMR_RELOAD 8'h01

`define RPT_FSW_DIV 4
`define RPT_RM_BITS 15
`define RPT_CCA_BASE 10'h040

`endif

// file: hdl/rpt_wake_timer.v
// Two-stage sleep interval timer: prescale times count slow ticks.
// Assumes slow_tick_i is a one-cycle pulse on the system clock.
`timescale 1ns/1ns
module rpt_wake_timer #(
  parameter W = 8
) (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire start_i,
  input wire stop_i,
  input wire slow_tick_i,
  input wire [W-1:0] prescale_i,
  input wire [W-1:0] count_i,
  output reg expire_o,
  output reg running_o
);
  reg [W-1:0] pre_q;
  reg [W-1:0] cnt_q;
  reg [W-1:0] pre_ld_q;

  ////////////////////////////////////////////////////////////////////
  // Zero in either field counts the same as one
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pre_q <= {W{1'b0}};
      cnt_q <= {W{1'b0}};
      pre_ld_q <= {W{1'b0}};
      expire_o <= 1'b0;
      running_o <= 1'b0;
    end
    else
    begin
      expire_o <= 1'b0;
      if (start_i)
      begin
        pre_q <= prescale_i;
        pre_ld_q <= prescale_i;
        cnt_q <= count_i;
        running_o <= 1'b1;
      end
      else if (stop_i)
        running_o <= 1'b0;
      else if (running_o && slow_tick_i)
      begin
        if (pre_q <= {{(W-1){1'b0}}, 1'b1})
        begin
          pre_q <= pre_ld_q; // [RQ18]
          if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
          begin
            expire_o <= 1'b1; // [RQ1] [RQ2]
            running_o <= 1'b0;
          end
          else
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
        else
          pre_q <= pre_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// file: hdl/rpt_backoff_rng.v
// Back-off random generator: 16-bit Galois shift register.
// Assumes step_i and load_i are single-cycle pulses.
`timescale 1ns/1ns
module rpt_backoff_rng (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire load_i,
  input wire step_i,
  input wire [15:0] seed_i,
  output reg [15:0] value_o
);
  // All-zero state would lock up, so a zero seed loads as one
  always @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      value_o <= 16'hff00;
    else if (load_i)
      value_o <= (seed_i == 16'h0000) ? 16'h0001 : seed_i; // [RQ15]
    else if (step_i)
      value_o <= {1'b0, value_o[15:1]} ^
        (value_o[0] ? 16'hb400 : 16'h0000);
  end
endmodule

// file: dv/rpt_host_model.sv
// Host side of the serial configuration port plus the slow clock pin.
// Assumes the bench calls xfer at a falling edge of clk_sys_i.
`timescale 1ns/1ns
module rpt_host_model (
  input wire clk_sys_i,
  input wire spi_miso_i,
  output logic spi_sclk_o,
  output logic spi_mosi_o,
  output logic spi_csn_o,
  output logic gpio_slow_clk_o
);
  initial
  begin
    spi_sclk_o = 1'b0;
    spi_mosi_o = 1'b0;
    spi_csn_o = 1'b1;
    gpio_slow_clk_o = 1'b0;
  end
  // Free running 34.7kHz clock on the pin, as the host must supply
  always #14409 gpio_slow_clk_o = ~gpio_slow_clk_o;
  ////////////////////////////////////////
  // Mode 0, MSB first; six clocks per level so synchronisers see it
  task automatic xfer(input [7:0] hdr, input [7:0] adr, input int n,
    input [63:0] wd, output [63:0] rd);
    logic [79:0] sh;
    sh = {hdr, adr, wd};
    rd = 64'h0;
    spi_csn_o = 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++)
    begin
      spi_mosi_o = sh[79 - i];
      repeat (6) @(negedge clk_sys_i);
      if (i > 15)
        rd[79 - i] = spi_miso_i;
      spi_sclk_o = 1'b1;
      repeat (6) @(negedge clk_sys_i);
      spi_sclk_o = 1'b0;
    end
    repeat (6) @(negedge clk_sys_i);
    spi_csn_o = 1'b1;
    // Released data line must not keep a valid look
    spi_mosi_o = ~spi_mosi_o;
    repeat (6) @(negedge clk_sys_i);
  endtask
endmodule

// file: dv/rpt_cfg_monitor.sv
// Port checker of the configuration bank top, bound into rpt_top.
// Assumes one clock domain with asynchronous active low reset.
`timescale 1ns/1ns
module rpt_cfg_monitor (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire spi_csn_i,
  input wire spi_miso_oe_o,
  input wire low_duty_cycle_mode_i,
  input wire carrier_sense_access_enable_i,
  input wire seed_reload_i,
  input wire backoff_step_i,
  input wire wake_o,
  input wire [15:0] backoff_rand_o,
  input wire [5:0] backoff_unit_prescale_o,
  input wire [9:0] cca_bit_periods_o,
  input wire [3:0] listen_length_o,
  input wire [2:0] backoff_cycle_limit_o,
  input wire [31:0] tx_control_field_o,
  input wire regulator_on_o,
  input wire smps_switch_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  wire acc_en = carrier_sense_access_enable_i;
  ////////////////////////////////////////
  sequence s_gen_idle;
    acc_en && !backoff_step_i && !seed_reload_i ##1 acc_en;
  endsequence
  sequence s_gen_step;
    acc_en && backoff_step_i && !seed_reload_i ##1 acc_en;
  endsequence
  // Five cycles covers the two-stage synchroniser plus output flop
  sequence s_cs_idle;
    spi_csn_i [*5];
  endsequence
  a_reset_vals:
    assert property ($rose(nrst_i) |-> backoff_unit_prescale_o == 6'h01
      && cca_bit_periods_o == 10'h040 && listen_length_o == 4'h0
      && backoff_cycle_limit_o == 3'h0 && tx_control_field_o == 32'h0)
    else $error("config outputs not at reset values");
  a_cca_legal:
    assert property (cca_bit_periods_o inside
      {10'h040, 10'h080, 10'h100, 10'h200})
    else $error("assessment period out of set");
  a_wake_single:
    assert property (wake_o |=> !wake_o)
    else $error("wake pulse longer than one cycle");
  a_wake_mode_off:
    assert property (!low_duty_cycle_mode_i [*4] |-> !wake_o)
    else $error("wake while duty cycle mode off");
  a_rand_gated:
    assert property (!acc_en |=> backoff_rand_o == 16'h0000)
    else $error("random value shown while access off");
  a_rand_hold:
    assert property (s_gen_idle |=> $stable(backoff_rand_o))
    else $error("generator moved without a step");
  a_rand_step:
    assert property (s_gen_step |=> backoff_rand_o != $past(backoff_rand_o))
    else $error("generator did not advance on step");
  a_reg_quiet:
    assert property (!regulator_on_o && $past(regulator_on_o) == 1'b0
      |-> !smps_switch_o)
    else $error("switch pulse with regulator off");
  a_oe_idle:
    assert property (s_cs_idle |-> !spi_miso_oe_o)
    else $error("data out enabled while deselected");
endmodule
bind rpt_top rpt_cfg_monitor u_mon (.clk_sys_i, .nrst_i, .spi_csn_i,
  .spi_miso_oe_o, .low_duty_cycle_mode_i, .carrier_sense_access_enable_i,
  .seed_reload_i, .backoff_step_i, .wake_o, .backoff_rand_o,
  .backoff_unit_prescale_o, .cca_bit_periods_o, .listen_length_o,
  .backoff_cycle_limit_o, .tx_control_field_o, .regulator_on_o,
  .smps_switch_o);

// file: dv/tb_top.sv
// Self-checking bench of the configuration bank top.
// Assumes the host model owns the serial pins and the slow clock pin.
`timescale 1ns/1ns
module tb_top;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic spi_sclk_i, spi_mosi_i, spi_csn_i, gpio_slow_clk_i;
  logic rco_tick_i = 1'b0, sleep_enter_i = 1'b0, sync_detect_i = 1'b0;
  logic low_duty_cycle_mode_i = 1'b0, reload_on_sync_enable_i = 1'b0;
  logic seed_reload_i = 1'b0, backoff_step_i = 1'b0;
  logic carrier_sense_access_enable_i = 1'b0;
  logic spi_miso_o, spi_miso_oe_o, wake_o, regulator_on_o, smps_switch_o;
  logic temp_sensor_buffer_enable_o, external_slow_clock_select_o;
  logic [15:0] backoff_rand_o;
  logic [5:0] backoff_unit_prescale_o;
  logic [9:0] cca_bit_periods_o;
  logic [3:0] listen_length_o;
  logic [2:0] backoff_cycle_limit_o;
  logic [31:0] tx_control_field_o;
  logic [63:0] rd;
  int miscompares = 0, check_count = 0, cyc = 0, wakes = 0;
  logic [7:0] ra [19] = '{8'h55, 8'h56, 8'h57, 8'h58, 8'h64, 8'h65, 8'h66,
    8'h67, 8'h68, 8'h69, 8'h6a, 8'h6b, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8,
    8'hb2, 8'h59};
  logic [7:0] ev [3][19] = '{
    '{1, 0, 1, 0, 8'hff, 0, 4, 0, 0, 0, 0, 0, 8'h0c, 8'h20, 0, 8'he1, 0,
      8'h42, 0},
    '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf7, 8'hff, 8'hff,
      8'hff, 8'hff, 8'h6c, 8'hff, 8'hff, 8'he9, 0, 8'h42, 0},
    '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8'he1, 0, 8'h42, 0}};

  always #10 clk_sys_i = ~clk_sys_i;
  rpt_top u_dut (.clk_sys_i, .nrst_i, .spi_sclk_i, .spi_mosi_i, .spi_csn_i,
    .spi_miso_o, .spi_miso_oe_o, .rco_tick_i, .gpio_slow_clk_i,
    .sleep_enter_i, .low_duty_cycle_mode_i, .sync_detect_i,
    .reload_on_sync_enable_i, .seed_reload_i, .carrier_sense_access_enable_i,
    .backoff_step_i, .wake_o, .backoff_rand_o, .backoff_unit_prescale_o,
    .cca_bit_periods_o, .listen_length_o, .backoff_cycle_limit_o,
    .tx_control_field_o, .regulator_on_o, .smps_switch_o,
    .temp_sensor_buffer_enable_o, .external_slow_clock_select_o);
  // Undriven data out line is pulled high
  rpt_host_model u_host (.clk_sys_i,
    .spi_miso_i(spi_miso_oe_o ? spi_miso_o : 1'b1), .spi_sclk_o(spi_sclk_i),
    .spi_mosi_o(spi_mosi_i), .spi_csn_o(spi_csn_i),
    .gpio_slow_clk_o(gpio_slow_clk_i));
  ////////////////////////////////////////
  task automatic results;
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    wakes += (wake_o === 1'b1);
    if (cyc == 70000)
    begin
      miscompares++;
      results;
    end
  end
  task automatic check(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input [7:0] a, input [7:0] d);
    u_host.xfer(8'h00, a, 1, {d, 56'h0}, rd);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys_i);
    s = 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic t_regs(input int k, input [7:0] v);
    if (k > 0)
      foreach (ra[i]) wr(ra[i], v);
    foreach (ra[i])
    begin
      u_host.xfer(8'h01, ra[i], 1, 64'h0, rd);
      check($sformatf("reg %h", ra[i]), ev[k][i], rd[63:56]);
    end
    check("unit", k == 0 ? 1 : v[5:0], backoff_unit_prescale_o);
    check("cca", v[0] ? 512 : 64, cca_bit_periods_o);
    check("len", v[7:4], listen_length_o);
    check("lim", v[2:0], backoff_cycle_limit_o);
    check("txc", {4{v}}, tx_control_field_o);
    check("regon", !v[5], regulator_on_o);
    check("tsb", v[6], temp_sensor_buffer_enable_o);
    check("ext", v[3], external_slow_clock_select_o);
  endtask
  task automatic t_burst;
    u_host.xfer(8'h00, 8'h64, 8, 64'h1234_0400_1122_3344, rd);
    u_host.xfer(8'h01, 8'h64, 8, 64'h0, rd);
    check("seed", 32'h1234_0400, rd[63:32]);
    check("ctl", 32'h1122_3344, rd[31:0]);
    check("txc", 32'h1122_3344, tx_control_field_o);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h66, {6'h15, c[1:0]});
      check("unit", 6'h15, backoff_unit_prescale_o);
      check("cca", 64 << c, cca_bit_periods_o);
    end
  endtask
  task automatic rate(input [15:0] km, input int e);
    int n;
    n = 0;
    u_host.xfer(8'h00, 8'ha5, 2, {km, 48'h0}, rd);
    repeat (1024) @(negedge clk_sys_i) n += (smps_switch_o === 1'b1);
    check("switch", e, n);
  endtask
  task automatic ticks(input int e);
    int w, g;
    w = wakes;
    g = 0;
    for (int k = 1; k < 13; k++)
    begin
      pulse(rco_tick_i);
      repeat (8) @(negedge clk_sys_i);
      if (g == 0 && wakes != w)
        g = k;
    end
    check("ticks", e, g);
  endtask
  task automatic t_timer;
    int w;
    low_duty_cycle_mode_i = 1'b1;
    u_host.xfer(8'h00, 8'h55, 4, 64'h0203_0102_0000_0000, rd);
    pulse(sleep_enter_i);
    ticks(6);
    pulse(sleep_enter_i);
    u_host.xfer(8'h80, 8'h01, 0, 64'h0, rd);
    ticks(2);
    pulse(sleep_enter_i);
    ticks(6);
    reload_on_sync_enable_i = 1'b1;
    pulse(sleep_enter_i);
    pulse(sync_detect_i);
    ticks(2);
    reload_on_sync_enable_i = 1'b0;
    pulse(sleep_enter_i);
    pulse(sync_detect_i);
    ticks(6);
    low_duty_cycle_mode_i = 1'b0;
    pulse(sleep_enter_i);
    ticks(0);
    low_duty_cycle_mode_i = 1'b1;
    wr(8'ha7, 8'h08);
    u_host.xfer(8'h00, 8'h55, 2, 64'h0101_0000_0000_0000, rd);
    w = wakes;
    pulse(sleep_enter_i);
    repeat (3000) @(negedge clk_sys_i);
    check("pinwake", 1, wakes - w);
    wr(8'ha7, 8'h00);
  endtask
  task automatic t_rng;
    logic [15:0] s;
    s = 16'h1234;
    carrier_sense_access_enable_i = 1'b1;
    u_host.xfer(8'h00, 8'h64, 2, {s, 48'h0}, rd);
    pulse(seed_reload_i);
    repeat (2) @(negedge clk_sys_i);
    check("seed", s, backoff_rand_o);
    repeat (5)
    begin
      pulse(backoff_step_i);
      repeat (2) @(negedge clk_sys_i);
      s = (s >> 1) ^ (s[0] ? 16'hb400 : 16'h0000);
      check("rand", s, backoff_rand_o);
    end
    carrier_sense_access_enable_i = 1'b0;
    pulse(backoff_step_i);
    check("off", 0, backoff_rand_o);
    carrier_sense_access_enable_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    check("held", s, backoff_rand_o);
    u_host.xfer(8'h00, 8'h64, 2, 64'h0, rd);
    pulse(seed_reload_i);
    repeat (2) @(negedge clk_sys_i);
    check("zero", 1, backoff_rand_o);
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_regs(0, 8'h00);
    t_regs(1, 8'hff);
    t_regs(2, 8'h00);
    t_burst;
    rate(16'h0000, 256);
    rate(16'hc000, 512);
    rate(16'h8100, 8);
    rate(16'h8080, 4);
    wr(8'ha4, 8'h20);
    rate(16'h8080, 0);
    wr(8'ha4, 8'h0c);
    t_timer;
    t_rng;
    results;
  end
endmodule
